/* design/pir_legacy_map.sv */
// In legacy mode, steers each routed line onto the legacy interrupt that its selection names.
// Assumes selections were checked on write; illegal codes are still ignored here.
`default_nettype none

module pir_legacy_map (
    pir_route_if.map rt
);

    logic [15:0] mask;

    always_comb begin
        mask = '0;
        for (int i = 0; i < pir_pkg::NUM_LINES; i++) begin
            // Several lines may land on one legacy interrupt and are ORed there.
            if (!rt.adv && rt.req[i] && rt.sel[i] != 4'h0 && pir_pkg::LINE_OK[rt.sel[i]]) begin
                mask[rt.sel[i]] = 1'b1;
            end
        end
    end

    assign rt.legacy_mask = mask;

    for (genvar g = 0; g < pir_pkg::NUM_LINES; g++) begin : g_chk
        a_steer_hit: assert property (@(posedge rt.clk) disable iff (!rt.rst_n)
            (!rt.adv && rt.req[g] && rt.sel[g] != 4'h0 && pir_pkg::LINE_OK[rt.sel[g]])
            |-> rt.legacy_mask[rt.sel[g]])
            else $error("Routed line not steered to its selected interrupt.");
    end

    a_fixed_free: assert property (@(posedge rt.clk) disable iff (!rt.rst_n)
        rt.legacy_mask[pir_pkg::IRQ_CASCADE] == 1'b0 && rt.legacy_mask[pir_pkg::IRQ_TIMER] == 1'b0
        && rt.legacy_mask[pir_pkg::IRQ_COPROC] == 1'b0 && rt.legacy_mask[pir_pkg::IRQ_RTC] == 1'b0)
        else $error("Routed line reached a reserved legacy interrupt.");

    a_adv_no_steer: assert property (@(posedge rt.clk) disable iff (!rt.rst_n)
        rt.adv |-> rt.legacy_mask == 16'h0000)
        else $error("Legacy steering active in advanced mode.");

endmodule : pir_legacy_map

`default_nettype wire

/* design/pir_line_merge.sv */
// Combines the active-low sources tied to one routed line into a request.
// Assumes unused source positions are held high by the instantiating logic.
`default_nettype none

module pir_line_merge #(
    parameter int N = 3
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] src_n,
    output logic              req
);

    pir_pkg::pir_merge_st_t s_r;
    pir_pkg::pir_merge_st_t s_nxt;

    always_comb begin
        s_nxt     = s_r;
        s_nxt.req = ~(&src_n);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req = s_r.req;

    a_share_held: assert property (@(posedge clk) disable iff (!rst_n)
        (!(&src_n)) [*2] |-> req ##1 req)
        else $error("Shared line dropped while a source was asserting.");

    a_share_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (&src_n) |=> !req)
        else $error("Shared line asserted with no source asserting.");

endmodule : pir_line_merge

`default_nettype wire

/* design/pir_pkg.sv */
// Constants and types shared by the interrupt router files.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
`default_nettype none

package pir_pkg;

    localparam int NUM_LINES    = 8;
    localparam int NUM_LEGACY   = 16;
    localparam int NUM_VECTORS  = 24;
    localparam int ADV_BASE     = 16;
    localparam int SEL_W        = 4;
    localparam int SRC_PER_LINE = 3;
    localparam int ADDR_W       = 8;
    localparam int DATA_W       = 8;

    localparam logic [7:0] REG_MODE      = 8'h00;
    localparam logic [7:0] REG_SEL_BASE  = 8'h01;
    localparam logic [7:0] REG_SER1      = 8'h09;
    localparam logic [7:0] REG_SER2      = 8'h0A;
    localparam logic [7:0] REG_PAR1      = 8'h0B;
    localparam logic [7:0] REG_LINE_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_LO    = 8'h0D;
    localparam logic [7:0] REG_IRQ_MID   = 8'h0E;
    localparam logic [7:0] REG_IRQ_HI    = 8'h0F;
    localparam logic [7:0] SEL_COUNT     = 8'h08;

    localparam int MODE_ADV_BIT = 0;

    localparam int IRQ_TIMER   = 0;
    localparam int IRQ_KBD     = 1;
    localparam int IRQ_CASCADE = 2;
    localparam int IRQ_RTC     = 8;
    localparam int IRQ_SMBUS   = 9;
    localparam int IRQ_COPROC  = 13;

    localparam logic [3:0] RST_SER1 = 4'h4;
    localparam logic [3:0] RST_SER2 = 4'h3;
    localparam logic [3:0] RST_PAR1 = 4'h7;
    localparam logic [3:0] RST_SEL  = 4'h0;
    localparam logic       RST_ADV  = 1'b0;
    localparam logic [3:0] SEL_SMBUS = 4'h9;

    // Legal codes for a routed line (0 means unrouted) and for reassigned ports.
    localparam logic [15:0] LINE_OK = 16'hDEF9;
    localparam logic [15:0] DEV_OK  = 16'hDCF8;

    localparam int LINE_A = 0;
    localparam int LINE_B = 1;
    localparam int LINE_C = 2;
    localparam int LINE_D = 3;
    localparam int LINE_E = 4;
    localparam int LINE_F = 5;
    localparam int LINE_G = 6;
    localparam int LINE_H = 7;

    // Line reached by pins INTA..INTD of each slot.
    localparam int SLOT1_LINE [4] = '{LINE_F, LINE_G, LINE_H, LINE_E};
    localparam int SLOT2_LINE [4] = '{LINE_G, LINE_F, LINE_E, LINE_H};
    localparam int SLOT3_LINE [4] = '{LINE_C, LINE_D, LINE_B, LINE_A};

    localparam int COL_SLOT13  = 0;
    localparam int COL_SLOT2   = 1;
    localparam int COL_ONBOARD = 2;

    typedef struct packed {
        logic req;
    } pir_merge_st_t;

    typedef struct packed {
        logic                  adv;
        logic [7:0][3:0]       sel;
        logic [3:0]            ser1;
        logic [3:0]            ser2;
        logic [3:0]            par1;
        logic [23:0]           irq;
        logic                  nmi;
        logic [7:0]            rd_data;
    } pir_top_st_t;

endpackage : pir_pkg

`default_nettype wire

/* design/pir_route_if.sv */
// Carries routed line requests and legacy steering between the top and the mapper.
// Assumes clock and reset come from the top of the router.
`default_nettype none

interface pir_route_if (
    input wire logic clk,
    input wire logic rst_n
);
    logic [7:0]      req;
    logic [7:0][3:0] sel;
    logic            adv;
    logic [15:0]     legacy_mask;

    modport ctrl (input clk, input rst_n, output req, output sel, output adv,
                  input legacy_mask);
    modport map (input clk, input rst_n, input req, input sel, input adv,
                 output legacy_mask);
endinterface : pir_route_if

`default_nettype wire

/* design/pir_router.sv */
// Top of the interrupt router: slot wiring, line merging, legacy and advanced delivery.
// Assumes all inputs are synchronous to clk and registers are reached over a plain port.
`default_nettype none

module pir_router (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] slot1_int_n,
    input  wire logic [3:0] slot2_int_n,
    input  wire logic [3:0] slot3_int_n,
    input  wire logic       nic_int_n,
    input  wire logic       link_int_n,
    input  wire logic       timer_req,
    input  wire logic       kbd_req,
    input  wire logic       cascade_req,
    input  wire logic       rtc_req,
    input  wire logic       coproc_req,
    input  wire logic       smbus_req,
    input  wire logic       first_serial_port_req,
    input  wire logic       second_serial_port_req,
    input  wire logic       first_parallel_port_req,
    input  wire logic       io_chk,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata,
    output logic [23:0]     irq_out,
    output logic            nmi_out
);

    pir_pkg::pir_top_st_t s_r;
    pir_pkg::pir_top_st_t s_nxt;

    logic [7:0][2:0] src_n;
    logic [7:0]      line_req;
    logic [7:0]      sel_off;
    logic [2:0]      sel_idx;
    logic            sel_hit;

    pir_route_if rt (
        .clk   (clk),
        .rst_n (rst_n)
    );

    // Fixed board wiring: each pin lands on one line and one column.
    always_comb begin
        src_n = '1;
        for (int p = 0; p < 4; p++) begin
            src_n[pir_pkg::SLOT1_LINE[p]][pir_pkg::COL_SLOT13] = slot1_int_n[p];
            src_n[pir_pkg::SLOT2_LINE[p]][pir_pkg::COL_SLOT2]  = slot2_int_n[p];
            src_n[pir_pkg::SLOT3_LINE[p]][pir_pkg::COL_SLOT13] = slot3_int_n[p];
        end
        src_n[pir_pkg::LINE_E][pir_pkg::COL_ONBOARD] = nic_int_n;
        src_n[pir_pkg::LINE_B][pir_pkg::COL_ONBOARD] = link_int_n;
    end

    for (genvar g = 0; g < pir_pkg::NUM_LINES; g++) begin : g_line
        pir_line_merge #(
            .N (pir_pkg::SRC_PER_LINE)
        ) u_merge (
            .clk   (clk),
            .rst_n (rst_n),
            .src_n (src_n[g]),
            .req   (line_req[g])
        );
    end

    assign rt.req = line_req;
    assign rt.sel = s_r.sel;
    assign rt.adv = s_r.adv;

    pir_legacy_map u_map (
        .rt (rt)
    );

    assign sel_off = reg_addr - pir_pkg::REG_SEL_BASE;
    assign sel_idx = sel_off[2:0];
    assign sel_hit = (reg_addr >= pir_pkg::REG_SEL_BASE) && (sel_off < pir_pkg::SEL_COUNT);

    always_comb begin
        s_nxt = s_r;

        // Register writes; illegal codes leave the register unchanged.
        if (reg_wr) begin
            if (reg_addr == pir_pkg::REG_MODE) begin
                s_nxt.adv = reg_wdata[pir_pkg::MODE_ADV_BIT];
            end else if (sel_hit) begin
                if (reg_wdata[7:4] == 4'h0 && pir_pkg::LINE_OK[reg_wdata[3:0]]) begin
                    s_nxt.sel[sel_idx] = reg_wdata[3:0];
                end
            end else if (reg_wdata[7:4] == 4'h0 && pir_pkg::DEV_OK[reg_wdata[3:0]]) begin
                if (reg_addr == pir_pkg::REG_SER1) begin
                    s_nxt.ser1 = reg_wdata[3:0];
                end else if (reg_addr == pir_pkg::REG_SER2) begin
                    s_nxt.ser2 = reg_wdata[3:0];
                end else if (reg_addr == pir_pkg::REG_PAR1) begin
                    s_nxt.par1 = reg_wdata[3:0];
                end
            end
        end

        // Interrupt delivery from the present configuration and line state.
        s_nxt.irq = '0;
        s_nxt.irq[pir_pkg::IRQ_TIMER]   = timer_req;
        s_nxt.irq[pir_pkg::IRQ_KBD]     = kbd_req;
        s_nxt.irq[pir_pkg::IRQ_CASCADE] = cascade_req;
        s_nxt.irq[pir_pkg::IRQ_RTC]     = rtc_req;
        s_nxt.irq[pir_pkg::IRQ_COPROC]  = coproc_req;
        s_nxt.irq[pir_pkg::IRQ_SMBUS]   = smbus_req;
        s_nxt.irq[15:0] = s_nxt.irq[15:0] | rt.legacy_mask;
        s_nxt.irq[s_r.ser1] = s_nxt.irq[s_r.ser1] | first_serial_port_req;
        s_nxt.irq[s_r.ser2] = s_nxt.irq[s_r.ser2] | second_serial_port_req;
        s_nxt.irq[s_r.par1] = s_nxt.irq[s_r.par1] | first_parallel_port_req;
        if (s_r.adv) begin
            s_nxt.irq[23:16] = line_req;
        end else begin
            s_nxt.irq[23:16] = 8'h00;
        end
        s_nxt.nmi = io_chk;

        // Read data stand only in the cycle after the read strobe.
        s_nxt.rd_data = 8'h00;
        if (reg_rd) begin
            if (reg_addr == pir_pkg::REG_MODE) begin
                s_nxt.rd_data = {7'h00, s_r.adv};
            end else if (sel_hit) begin
                s_nxt.rd_data = {4'h0, s_r.sel[sel_idx]};
            end else if (reg_addr == pir_pkg::REG_SER1) begin
                s_nxt.rd_data = {4'h0, s_r.ser1};
            end else if (reg_addr == pir_pkg::REG_SER2) begin
                s_nxt.rd_data = {4'h0, s_r.ser2};
            end else if (reg_addr == pir_pkg::REG_PAR1) begin
                s_nxt.rd_data = {4'h0, s_r.par1};
            end else if (reg_addr == pir_pkg::REG_LINE_STAT) begin
                s_nxt.rd_data = line_req;
            end else if (reg_addr == pir_pkg::REG_IRQ_LO) begin
                s_nxt.rd_data = s_r.irq[7:0];
            end else if (reg_addr == pir_pkg::REG_IRQ_MID) begin
                s_nxt.rd_data = s_r.irq[15:8];
            end else if (reg_addr == pir_pkg::REG_IRQ_HI) begin
                s_nxt.rd_data = s_r.irq[23:16];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r         <= '0;
            s_r.adv     <= pir_pkg::RST_ADV;
            s_r.sel     <= {8{pir_pkg::RST_SEL}};
            s_r.ser1    <= pir_pkg::RST_SER1;
            s_r.ser2    <= pir_pkg::RST_SER2;
            s_r.par1    <= pir_pkg::RST_PAR1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign irq_out   = s_r.irq;
    assign nmi_out   = s_r.nmi;
    assign reg_rdata = s_r.rd_data;

    sequence s_released;
        $past(rst_n) && rst_n;
    endsequence

    sequence s_slot1a_adv;
        !slot1_int_n[0] ##1 s_r.adv;
    endsequence

    sequence s_slot3a_legacy;
        !slot3_int_n[0] ##1 (!s_r.adv && s_r.sel[pir_pkg::LINE_C] == 4'hA);
    endsequence

    a_legacy_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        s_released ##0 !$past(s_r.adv) |-> irq_out[23:16] == 8'h00)
        else $error("Advanced vector asserted in legacy mode.");

    a_adv_order: assert property (@(posedge clk) disable iff (!rst_n)
        s_released ##0 $past(s_r.adv) |-> irq_out[23:16] == $past(line_req))
        else $error("Advanced vectors do not follow lines A to H.");

    a_slot_path: assert property (@(posedge clk) disable iff (!rst_n)
        s_slot1a_adv |=> irq_out[pir_pkg::ADV_BASE + pir_pkg::LINE_F])
        else $error("Slot 1 INTA did not reach line F.");

    a_legacy_path: assert property (@(posedge clk) disable iff (!rst_n)
        s_slot3a_legacy |=> irq_out[10])
        else $error("Slot 3 INTA did not reach its steered legacy interrupt.");

    a_nic_line: assert property (@(posedge clk) disable iff (!rst_n)
        !nic_int_n |=> line_req[pir_pkg::LINE_E])
        else $error("Network controller did not drive line E.");

    a_fixed_irqs: assert property (@(posedge clk) disable iff (!rst_n)
        s_released |-> irq_out[pir_pkg::IRQ_TIMER] == $past(timer_req)
        && irq_out[pir_pkg::IRQ_CASCADE] == $past(cascade_req))
        else $error("Fixed legacy interrupt does not follow its source.");

    a_smbus_kept: assert property (@(posedge clk) disable iff (!rst_n)
        reg_wr && reg_addr == pir_pkg::REG_SER1 && reg_wdata == {4'h0, pir_pkg::SEL_SMBUS}
        |=> s_r.ser1 == $past(s_r.ser1))
        else $error("Serial port accepted the management bus interrupt.");

    a_nmi_follow: assert property (@(posedge clk) disable iff (!rst_n)
        s_released |-> nmi_out == $past(io_chk))
        else $error("Non-maskable output does not follow channel check.");

    a_dev_default: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(rst_n) |-> s_r.ser1 == pir_pkg::RST_SER1 && s_r.ser2 == pir_pkg::RST_SER2
        && s_r.par1 == pir_pkg::RST_PAR1)
        else $error("Port interrupt defaults wrong after reset.");

    a_read_once: assert property (@(posedge clk) disable iff (!rst_n)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("Read data present outside the read answer cycle.");

endmodule : pir_router

`default_nettype wire

/* test/pir_card_model.sv */
// Behavioural add-in cards and onboard controllers driving the shared request pins.
// Assumes the bench raises one request bit per source; idle pins are pulled up.
`default_nettype none

module pir_card_model (
    input  wire logic [13:0] src_req,
    output logic      [3:0]  slot1_int_n,
    output logic      [3:0]  slot2_int_n,
    output logic      [3:0]  slot3_int_n,
    output logic             nic_int_n,
    output logic             link_int_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bit 0 of each slot is the first pin a card uses, then pins 1 to 3 in order.
    // A released pin returns to the pulled-up high level, so requests are active low.
    assign slot1_int_n = ~src_req[3:0];
    assign slot2_int_n = ~src_req[7:4];
    assign slot3_int_n = ~src_req[11:8];
    assign nic_int_n   = ~src_req[12];
    assign link_int_n  = ~src_req[13];
endmodule : pir_card_model

`default_nettype wire

/* test/pir_router_test.sv */
// Self-checking bench for the interrupt router.
// Assumes the card model drives the shared pins and the bench drives all other inputs.
`default_nettype none

module pir_router_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk;
    logic        rst_n;
    logic [13:0] src_req;
    logic [9:0]  fx;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [23:0] irq_out;
    logic        nmi_out;
    logic [3:0]  s1_n;
    logic [3:0]  s2_n;
    logic [3:0]  s3_n;
    logic        nic_n;
    logic        link_n;
    logic [7:0]  rd_val;
    int          failures;
    int          cmp_count;
    int          line_of [14] = '{5, 6, 7, 4, 6, 5, 4, 7, 2, 3, 1, 0, 4, 1};
    int          src_of [8] = '{11, 13, 8, 9, 12, 0, 4, 2};
    int          codes [11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
    int          fixed_bit [9] = '{0, 1, 2, 8, 13, 9, 4, 3, 7};

    pir_card_model cards (.src_req(src_req), .slot1_int_n(s1_n), .slot2_int_n(s2_n),
                          .slot3_int_n(s3_n), .nic_int_n(nic_n), .link_int_n(link_n));

    pir_router dut (.clk(clk), .rst_n(rst_n), .slot1_int_n(s1_n), .slot2_int_n(s2_n),
                    .slot3_int_n(s3_n), .nic_int_n(nic_n), .link_int_n(link_n),
                    .timer_req(fx[0]), .kbd_req(fx[1]), .cascade_req(fx[2]),
                    .rtc_req(fx[3]), .coproc_req(fx[4]), .smbus_req(fx[5]),
                    .first_serial_port_req(fx[6]), .second_serial_port_req(fx[7]),
                    .first_parallel_port_req(fx[8]), .io_chk(fx[9]),
                    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
                    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_out(irq_out),
                    .nmi_out(nmi_out));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
        check({16'h0, rd_val}, {16'h0, exp}, what);
    endtask : rd_chk

    task automatic src_check(input int s, input logic [23:0] exp, input int line);
        @(posedge clk);
        src_req <= 14'h1 << s;
        wait_n(2);
        check(irq_out, exp, "routed interrupt");
        rd_chk(pir_pkg::REG_LINE_STAT, 8'h1 << line, "line status");
        @(posedge clk);
        src_req <= 14'h0;
        wait_n(2);
        check(irq_out, 24'h0, "routed interrupt released");
    endtask : src_check

    task automatic test_reset();
        check(irq_out, 24'h0, "irq after reset");
        check({23'h0, nmi_out}, 24'h0, "nmi after reset");
        rd_chk(pir_pkg::REG_MODE, 8'h00, "mode reset");
        rd_chk(pir_pkg::REG_SEL_BASE, 8'h00, "select reset");
        rd_chk(pir_pkg::REG_SER1, 8'h04, "ser1 reset");
        rd_chk(pir_pkg::REG_SER2, 8'h03, "ser2 reset");
        rd_chk(pir_pkg::REG_PAR1, 8'h07, "par1 reset");
        rd_chk(8'h20, 8'h00, "unmapped read");
        $display("test reset done");
    endtask : test_reset

    task automatic test_fixed();
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            fx <= 10'h1 << i;
            wait_n(1);
            check(irq_out, 24'h1 << fixed_bit[i], "fixed interrupt");
        end
        @(posedge clk);
        fx <= 10'h200;
        wait_n(1);
        check({23'h0, nmi_out}, 24'h1, "nmi raised");
        check(irq_out, 24'h0, "nmi apart from irq");
        @(posedge clk);
        fx <= 10'h0;
        wait_n(1);
        check({23'h0, nmi_out}, 24'h0, "nmi released");
        $display("test fixed done");
    endtask : test_fixed

    task automatic test_legacy();
        reg_write(pir_pkg::REG_MODE, 8'h00);
        for (int k = 0; k < 11; k++) begin
            reg_write(pir_pkg::REG_SEL_BASE + 8'(k % 8), 8'(codes[k]));
            src_check(src_of[k % 8], 24'h1 << codes[k], k % 8);
        end
        reg_write(pir_pkg::REG_SEL_BASE + 8'h3, 8'h0F);
        src_check(src_of[2], 24'h1 << 15, 2);
        src_check(src_of[3], 24'h1 << 15, 3);
        @(posedge clk);
        src_req <= 14'h0300;
        wait_n(2);
        check(irq_out, 24'h1 << 15, "two lines on one irq");
        rd_chk(pir_pkg::REG_IRQ_MID, 8'h80, "shared irq read");
        @(posedge clk);
        src_req <= 14'h0;
        wait_n(2);
        check(irq_out, 24'h0, "two lines released");
        reg_write(pir_pkg::REG_SEL_BASE, 8'h02);
        rd_chk(pir_pkg::REG_SEL_BASE, 8'h0C, "cascade select refused");
        reg_write(pir_pkg::REG_SEL_BASE, 8'h13);
        rd_chk(pir_pkg::REG_SEL_BASE, 8'h0C, "wide select refused");
        reg_write(pir_pkg::REG_SEL_BASE + 8'h2, 8'h0A);
        src_check(src_of[2], 24'h1 << 10, 2);
        $display("test legacy done");
    endtask : test_legacy

    task automatic test_ports();
        reg_write(pir_pkg::REG_SER1, 8'h09);
        rd_chk(pir_pkg::REG_SER1, 8'h04, "ser1 nine refused");
        reg_write(pir_pkg::REG_SER1, 8'h0A);
        rd_chk(pir_pkg::REG_SER1, 8'h0A, "ser1 reassigned");
        @(posedge clk);
        fx <= 10'h040;
        wait_n(1);
        check(irq_out, 24'h1 << 10, "ser1 on new irq");
        rd_chk(pir_pkg::REG_IRQ_LO, 8'h00, "old ser1 irq quiet");
        rd_chk(pir_pkg::REG_IRQ_MID, 8'h04, "ser1 irq read");
        @(posedge clk);
        fx <= 10'h0;
        wait_n(1);
        reg_write(pir_pkg::REG_SER2, 8'h0B);
        rd_chk(pir_pkg::REG_SER2, 8'h0B, "ser2 reassigned");
        reg_write(pir_pkg::REG_PAR1, 8'h05);
        rd_chk(pir_pkg::REG_PAR1, 8'h05, "par1 reassigned");
        $display("test ports done");
    endtask : test_ports

    task automatic test_advanced();
        reg_write(pir_pkg::REG_MODE, 8'h01);
        for (int s = 0; s < 14; s++) begin
            src_check(s, 24'h1 << (16 + line_of[s]), line_of[s]);
        end
        @(posedge clk);
        src_req <= 14'h1008;
        wait_n(2);
        check(irq_out, 24'h1 << 20, "shared line both");
        rd_chk(pir_pkg::REG_IRQ_HI, 8'h10, "advanced irq read");
        @(posedge clk);
        src_req <= 14'h1000;
        wait_n(2);
        check(irq_out, 24'h1 << 20, "shared line one left");
        @(posedge clk);
        src_req <= 14'h0;
        wait_n(2);
        check(irq_out, 24'h0, "shared line idle");
        $display("test advanced done");
    endtask : test_advanced

    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("mismatch at %0t: run limit reached", $time);
        finish_test();
    end

    initial begin
        failures  = 0;
        cmp_count = 0;
        rst_n     = 1'b0;
        src_req   = 14'h0;
        fx        = 10'h0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wait_n(1);
        test_reset();
        test_fixed();
        test_legacy();
        test_ports();
        test_advanced();
        finish_test();
    end
endmodule : pir_router_test

`default_nettype wire
